//--- inc/vfp_irq_consts.svh
// offsets, field positions, reset values and vector constants of the irq block
`ifndef VFP_IRQ_CONSTS_SVH
`define VFP_IRQ_CONSTS_SVH

`define IRQ_REQ_OFS      12'h000
`define IRQ_EN_OFS       12'h004
`define IRQ_SRCSEL_OFS   12'h008
`define IRQ_EDGE_OFS     12'h00c
`define IRQ_CTRL_OFS     12'h010
`define IRQ_STAT_OFS     12'h014

`define IRQ_SLOTS        15
`define IRQ_REQ_RST      15'h0000
`define IRQ_EN_RST       15'h0000
`define IRQ_SRCSEL_RST   5'h00
`define IRQ_EDGE_RST     8'h00
`define IRQ_MASK_RST     1'b1

// source select fields
`define SEL_P2_BIT       0
`define SEL_P11_BIT      1
`define SEL_P12_BIT      2
`define SEL_P15_BIT      3
`define SEL_P16_BIT      4

// slot indices, index 0 is priority 2
`define SLOT_P2          0
`define SLOT_P3          1
`define SLOT_P4          2
`define SLOT_P5          3
`define SLOT_P6          4
`define SLOT_P7          5
`define SLOT_P8          6
`define SLOT_P9          7
`define SLOT_P10         8
`define SLOT_P11         9
`define SLOT_P12         10
`define SLOT_P13         11
`define SLOT_P14         12
`define SLOT_P15         13
`define SLOT_P16         14

`define VEC_RESET        16'hfffc
`define VEC_TOP_SLOT     16'hfffa
`define VEC_BREAK        16'hffdc
`define VEC_STEP         16'h0002

`endif

//--- inc/vfp_irq_pkg.sv
// types of the vectored fixed priority irq block
package vfp_irq_pkg;
  typedef enum logic [1:0] {
    ST_RESET_VEC,
    ST_RUN
  } irq_state_t;
endpackage

//--- rtl/vectored_fixed_priority_irq.sv
// vectored fixed priority interrupt controller with apb register access
//
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/10ps
`include "vfp_irq_consts.svh"

module vectored_fixed_priority_irq
  import vfp_irq_pkg::*;
#(
  parameter int NSLOT = `IRQ_SLOTS
) (
  input  wire logic        i_core_clk,
  input  wire logic        i_reset,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic      [31:0] prdata,
  output logic             pslverr,
  // pins and peripheral events
  input  wire logic        i_ext_irq_line_0,
  input  wire logic        i_ext_irq_line_1,
  input  wire logic        i_ext_irq_line_2,
  input  wire logic        i_ext_irq_line_3,
  input  wire logic        i_ext_irq_line_4,
  input  wire logic        i_counter_pin_0,
  input  wire logic        i_counter_pin_1,
  input  wire logic        i_counter_pin_2,
  input  wire logic        i_serial_a_selected,
  input  wire logic        i_serial_a_rx_done,
  input  wire logic        i_serial_a_tx_done,
  input  wire logic        i_serial_b_selected,
  input  wire logic        i_serial_b_done,
  input  wire logic        i_serial_c_selected,
  input  wire logic        i_serial_c_rx_done,
  input  wire logic        i_serial_c_tx_done,
  input  wire logic        i_timer_a_uflow,
  input  wire logic        i_timer_b_uflow,
  input  wire logic        i_timer_c_uflow,
  input  wire logic        i_timer_d_uflow,
  input  wire logic        i_timer_e_uflow,
  input  wire logic        i_adc_done,
  // processor core
  input  wire logic        i_mask_flag,
  input  wire logic        i_accept_point,
  input  wire logic        i_software_break_instruction,
  output logic             o_irq_pending,
  output logic             o_vector_valid,
  output logic      [15:0] o_vector_addr,
  output logic             o_stop_release
);

  // ********************************************************
  // helpers
  // ********************************************************
  function automatic logic edge_hit(input logic prev, input logic now,
                                    input logic rise);
    edge_hit = rise ? (!prev && now) : (prev && !now);
  endfunction

  function automatic logic [15:0] slot_vec(input logic [3:0] idx);
    slot_vec = 16'(`VEC_TOP_SLOT - 16'(idx) * `VEC_STEP);
  endfunction

  // ********************************************************
  // registers
  // ********************************************************
  logic [NSLOT-1:0] req;
  logic [NSLOT-1:0] en;
  logic [4:0]       srcsel;
  logic [7:0]       edge_sel;
  logic [7:0]       pin_prev;
  logic [NSLOT-1:0] set_req;
  logic [NSLOT-1:0] qual;
  logic [NSLOT-1:0] win;
  logic [3:0]       win_idx;
  logic             acc_maskable;
  logic             acc_break;
  irq_state_t       state;

  wire logic [7:0] pins = {i_counter_pin_2, i_counter_pin_1,
                           i_counter_pin_0, i_ext_irq_line_4,
                           i_ext_irq_line_3, i_ext_irq_line_2,
                           i_ext_irq_line_1, i_ext_irq_line_0};
  logic [7:0] pin_edge;

  wire logic wr_acc = psel && penable && pwrite;
  wire logic mapped = paddr inside {`IRQ_REQ_OFS, `IRQ_EN_OFS,
                                    `IRQ_SRCSEL_OFS, `IRQ_EDGE_OFS,
                                    `IRQ_CTRL_OFS, `IRQ_STAT_OFS};

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // ********************************************************
  // edge detection and source routing
  // ********************************************************
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      pin_prev <= 8'h00;
    end else begin
      pin_prev <= pins;
    end
  end

  always_comb begin
    for (int k = 0; k < 8; k++) begin
      pin_edge[k] = edge_hit(pin_prev[k], pins[k], edge_sel[k]);
    end
  end

  always_comb begin
    set_req = '0;
    set_req[`SLOT_P2] = srcsel[`SEL_P2_BIT] ? i_timer_c_uflow
                                            : pin_edge[0];
    set_req[`SLOT_P3] = pin_edge[1];
    set_req[`SLOT_P4] = i_serial_a_selected && i_serial_a_rx_done;
    set_req[`SLOT_P5] = i_serial_a_selected && i_serial_a_tx_done;
    set_req[`SLOT_P6] = i_timer_a_uflow;
    set_req[`SLOT_P7] = i_timer_b_uflow;
    set_req[`SLOT_P8] = i_timer_d_uflow;
    set_req[`SLOT_P9] = i_timer_e_uflow;
    set_req[`SLOT_P10] = pin_edge[5];
    set_req[`SLOT_P11] = srcsel[`SEL_P11_BIT] ?
        (i_serial_c_selected && i_serial_c_rx_done) : pin_edge[6];
    set_req[`SLOT_P12] = srcsel[`SEL_P12_BIT] ? i_timer_c_uflow
        : (i_serial_b_selected && i_serial_b_done);
    set_req[`SLOT_P13] = pin_edge[2];
    set_req[`SLOT_P14] = pin_edge[3];
    set_req[`SLOT_P15] = srcsel[`SEL_P15_BIT] ? pin_edge[7]
                                              : pin_edge[4];
    set_req[`SLOT_P16] = srcsel[`SEL_P16_BIT] ?
        (i_serial_c_selected && i_serial_c_tx_done) : i_adc_done;
  end

  // timer d underflow doubles as the stop release event
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      o_stop_release <= 1'b0;
    end else begin
      o_stop_release <= i_timer_d_uflow;
    end
  end

  // ********************************************************
  // fixed priority arbitration
  // ********************************************************
  always_comb begin
    qual    = req & en & {NSLOT{!i_mask_flag}};
    win     = '0;
    win_idx = 4'h0;
    for (int k = NSLOT - 1; k >= 0; k--) begin
      if (qual[k]) begin
        win     = '0;
        win[k]  = 1'b1;
        win_idx = 4'(k);
      end
    end
  end

  assign acc_maskable = (state == ST_RUN) && i_accept_point && (|qual);
  // break only wins when no maskable request qualifies
  assign acc_break = (state == ST_RUN) && i_accept_point && !(|qual)
                     && i_software_break_instruction;
  assign o_irq_pending = (|qual) || i_software_break_instruction;

  // ********************************************************
  // request bits: hardware set beats software clear
  // ********************************************************
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      req <= `IRQ_REQ_RST;
    end else begin
      req <= ((wr_acc && paddr == `IRQ_REQ_OFS)
              ? (req & pwdata[NSLOT-1:0]) : req)
             & ~(acc_maskable ? win : '0)
             | set_req;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      en       <= `IRQ_EN_RST;
      srcsel   <= `IRQ_SRCSEL_RST;
      edge_sel <= `IRQ_EDGE_RST;
    end else if (wr_acc) begin
      case (paddr)
        `IRQ_EN_OFS:     en       <= pwdata[NSLOT-1:0];
        `IRQ_SRCSEL_OFS: srcsel   <= pwdata[4:0];
        `IRQ_EDGE_OFS:   edge_sel <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // ********************************************************
  // vector output; reset fetch first
  // ********************************************************
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      state          <= ST_RESET_VEC;
      o_vector_valid <= 1'b0;
      o_vector_addr  <= 16'h0000;
    end else begin
      case (state)
        ST_RESET_VEC: begin
          o_vector_valid <= 1'b1;
          o_vector_addr  <= `VEC_RESET;
          state          <= ST_RUN;
        end
        ST_RUN: begin
          o_vector_valid <= acc_maskable || acc_break;
          if (acc_maskable) begin
            o_vector_addr <= slot_vec(win_idx);
          end else if (acc_break) begin
            o_vector_addr <= `VEC_BREAK;
          end
        end
        default: state <= ST_RUN;
      endcase
    end
  end

  // ********************************************************
  // register read
  // ********************************************************
  always_comb begin
    prdata = 32'h0000_0000;
    case (paddr)
      `IRQ_REQ_OFS:    prdata[NSLOT-1:0] = req;
      `IRQ_EN_OFS:     prdata[NSLOT-1:0] = en;
      `IRQ_SRCSEL_OFS: prdata[4:0]       = srcsel;
      `IRQ_EDGE_OFS:   prdata[7:0]       = edge_sel;
      `IRQ_STAT_OFS:   prdata[4:0]       = {|qual, win_idx};
      default:         prdata            = 32'h0000_0000;
    endcase
  end

  // ********************************************************
  // assertions
  // ********************************************************
  property p_vec_needs_cause;
    @(posedge i_core_clk) disable iff (i_reset)
    (state == ST_RUN && $past(state) == ST_RUN && o_vector_valid) |->
      $past(i_accept_point) && ($past(|qual) ||
      $past(i_software_break_instruction));
  endproperty
  a_vec_needs_cause: assert property (p_vec_needs_cause)
    else $error("vector without qualified cause");

  property p_masked_none;
    @(posedge i_core_clk) disable iff (i_reset)
    i_mask_flag && i_accept_point && !i_software_break_instruction
      && state == ST_RUN |=> !o_vector_valid;
  endproperty
  a_masked_none: assert property (p_masked_none)
    else $error("vector issued while masked");

  property p_break_vec;
    @(posedge i_core_clk) disable iff (i_reset)
    acc_break |=> o_vector_valid && o_vector_addr == 16'hffdc;
  endproperty
  a_break_vec: assert property (p_break_vec)
    else $error("break vector wrong");

  property p_break_nonmask;
    @(posedge i_core_clk) disable iff (i_reset)
    state == ST_RUN && i_accept_point && i_software_break_instruction
      && i_mask_flag |=> o_vector_valid;
  endproperty
  a_break_nonmask: assert property (p_break_nonmask)
    else $error("break was masked");

  property p_reset_vec;
    @(posedge i_core_clk) disable iff (i_reset)
    $rose(state == ST_RUN) |-> o_vector_valid
      && o_vector_addr == 16'hfffc;
  endproperty
  a_reset_vec: assert property (p_reset_vec)
    else $error("reset vector missing");

  property p_top_vec;
    @(posedge i_core_clk) disable iff (i_reset)
    acc_maskable && qual[0] |=> o_vector_addr == 16'hfffa;
  endproperty
  a_top_vec: assert property (p_top_vec)
    else $error("priority 2 vector wrong");

  property p_low_vec;
    @(posedge i_core_clk) disable iff (i_reset)
    acc_maskable && qual == 15'h4000 |=> o_vector_addr == 16'hffde;
  endproperty
  a_low_vec: assert property (p_low_vec)
    else $error("priority 16 vector wrong");

  property p_accept_clears;
    @(posedge i_core_clk) disable iff (i_reset)
    acc_maskable && !(|(set_req & win)) |=> !(|(req & $past(win)));
  endproperty
  a_accept_clears: assert property (p_accept_clears)
    else $error("accepted request bit not cleared");

  property p_loser_kept;
    @(posedge i_core_clk) disable iff (i_reset)
    acc_maskable && !(wr_acc && paddr == `IRQ_REQ_OFS) |=>
      (req & ($past(qual) & ~$past(win))) == ($past(qual) & ~$past(win));
  endproperty
  a_loser_kept: assert property (p_loser_kept)
    else $error("unaccepted request lost");

  property p_set_sticks;
    @(posedge i_core_clk) disable iff (i_reset)
    |set_req |=> (req & $past(set_req)) == $past(set_req);
  endproperty
  a_set_sticks: assert property (p_set_sticks)
    else $error("request event lost");

  property p_sw_never_sets;
    @(posedge i_core_clk) disable iff (i_reset)
    wr_acc && paddr == `IRQ_REQ_OFS && !(|set_req) |=>
      !(|(req & ~$past(req)));
  endproperty
  a_sw_never_sets: assert property (p_sw_never_sets)
    else $error("software write set a request bit");

  property p_routed_top;
    @(posedge i_core_clk) disable iff (i_reset)
    srcsel[`SEL_P2_BIT] && i_timer_c_uflow |=> req[`SLOT_P2];
  endproperty
  a_routed_top: assert property (p_routed_top)
    else $error("timer c not routed to priority 2 slot");

  property p_routed_p12;
    @(posedge i_core_clk) disable iff (i_reset)
    srcsel[`SEL_P12_BIT] && i_timer_c_uflow |=> req[`SLOT_P12];
  endproperty
  a_routed_p12: assert property (p_routed_p12)
    else $error("timer c not routed to priority 12 slot");

  property p_stop_follows;
    @(posedge i_core_clk) disable iff (i_reset)
    i_timer_d_uflow |=> o_stop_release;
  endproperty
  a_stop_follows: assert property (p_stop_follows)
    else $error("stop release event missing");

  c_maskable: cover property (@(posedge i_core_clk) acc_maskable);
  c_break:    cover property (@(posedge i_core_clk) acc_break);
  c_two_req:  cover property (@(posedge i_core_clk)
                acc_maskable && $countones(qual) > 1);
  c_routed:   cover property (@(posedge i_core_clk)
                srcsel[`SEL_P2_BIT] && i_timer_c_uflow);
  c_masked:   cover property (@(posedge i_core_clk)
                i_accept_point && i_mask_flag && (|(req & en)));

endmodule // vectored_fixed_priority_irq

//--- testbench/core_side_model.sv
// core side model: strobes accept points and records the vector answer
`timescale 1ns/10ps

module core_side_model (
  input  wire logic        i_core_clk,
  input  wire logic        i_reset,
  input  wire logic        i_take,
  input  wire logic        i_vector_valid,
  input  wire logic [15:0] i_vector_addr,
  output logic             o_accept_point,
  output logic             o_seen_valid,
  output logic      [15:0] o_seen_addr,
  output logic             o_done
);
  logic armed;

  // one strobe per request, like a single instruction boundary
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      o_accept_point <= 1'b0;
      armed          <= 1'b0;
    end else begin
      o_accept_point <= i_take;
      armed          <= o_accept_point;
    end
  end

  // valid lasts one cycle, so it is caught right after the strobe
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      o_seen_valid <= 1'b0;
      o_seen_addr  <= 16'h0000;
      o_done       <= 1'b0;
    end else if (i_take) begin
      o_done <= 1'b0;
    end else if (armed) begin
      o_seen_valid <= i_vector_valid;
      o_seen_addr  <= i_vector_addr;
      o_done       <= 1'b1;
    end
  end
endmodule // core_side_model

//--- testbench/vectored_fixed_priority_irq_tb_top.sv
// self-checking bench of the vectored fixed priority irq block
`timescale 1ns/10ps

module vectored_fixed_priority_irq_tb_top;
  // ****************
  // signals
  // ****************
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic [7:0]  pins;
  logic [10:0] ev;
  logic [2:0]  sel;
  logic        mask, software_break_instruction, take, accept, pend, vvalid, stop_rel;
  logic        seen_valid, done;
  logic [15:0] vaddr, seen_addr;
  int          num_errors, cmp_count;
  int          src_a[15] = '{16, 17, 0, 1, 5, 6, 8, 9, 21, 22, 2, 18, 19,
                             20, 10};
  logic [15:0] vec_a[15] = '{16'hfffa, 16'hfff8, 16'hfff6, 16'hfff4,
    16'hfff2, 16'hfff0, 16'hffee, 16'hffec, 16'hffea, 16'hffe8, 16'hffe6,
    16'hffe4, 16'hffe2, 16'hffe0, 16'hffde};
  int          src_b[3] = '{3, 23, 4};
  logic [15:0] vec_b[3] = '{16'hffe8, 16'hffe0, 16'hffde};

  initial clk = 1'b0;
  always #5 clk = ~clk;

  vectored_fixed_priority_irq DUT (.i_core_clk(clk), .i_reset(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .i_ext_irq_line_0(pins[0]), .i_ext_irq_line_1(pins[1]),
    .i_ext_irq_line_2(pins[2]), .i_ext_irq_line_3(pins[3]),
    .i_ext_irq_line_4(pins[4]), .i_counter_pin_0(pins[5]),
    .i_counter_pin_1(pins[6]), .i_counter_pin_2(pins[7]),
    .i_serial_a_selected(sel[0]), .i_serial_a_rx_done(ev[0]),
    .i_serial_a_tx_done(ev[1]), .i_serial_b_selected(sel[1]),
    .i_serial_b_done(ev[2]), .i_serial_c_selected(sel[2]),
    .i_serial_c_rx_done(ev[3]), .i_serial_c_tx_done(ev[4]),
    .i_timer_a_uflow(ev[5]), .i_timer_b_uflow(ev[6]),
    .i_timer_c_uflow(ev[7]), .i_timer_d_uflow(ev[8]),
    .i_timer_e_uflow(ev[9]), .i_adc_done(ev[10]), .i_mask_flag(mask),
    .i_accept_point(accept), .i_software_break_instruction(software_break_instruction),
    .o_irq_pending(pend), .o_vector_valid(vvalid), .o_vector_addr(vaddr),
    .o_stop_release(stop_rel));

  core_side_model core (.i_core_clk(clk), .i_reset(rst), .i_take(take),
    .i_vector_valid(vvalid), .i_vector_addr(vaddr),
    .o_accept_point(accept), .o_seen_valid(seen_valid),
    .o_seen_addr(seen_addr), .o_done(done));

  // ****************
  // tasks
  // ****************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdv = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // idle edge, so a following call never drives psel twice at once
    @(posedge clk);
  endtask

  task automatic stim(input int s);
    if (s >= 16) begin
      pins[s-16] <= 1'b1;
      repeat (2) @(posedge clk);
      pins[s-16] <= 1'b0;
    end else begin
      ev[s] <= 1'b1;
      @(posedge clk);
      ev[s] <= 1'b0;
    end
    repeat (2) @(posedge clk);
  endtask

  // valid is a one-cycle pulse, so the core model latches it for us
  task automatic take_chk(input logic v, input logic [15:0] a);
    int n;
    n = 0;
    take <= 1'b1;
    @(posedge clk);
    take <= 1'b0;
    @(posedge clk);
    while (done !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    if (n >= 20) num_errors++;
    chk(seen_valid, v);
    if (v) chk(seen_addr, a);
  endtask

  task automatic finish_test;
    $display("errors=%0d compares=%0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ****************
  // tests
  // ****************
  initial begin
    {rst, psel, penable, pwrite, paddr, pwdata} = '0;
    rst = 1'b1;
    {pins, ev, mask, software_break_instruction, take} = '0;
    sel = 3'b111;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk(vvalid, 1'b1);
    chk(vaddr, 16'hfffc);
    apb(1'b0, 12'h020, '0);
    chk(err, 1'b1);
    chk(rdv, 32'h0);
    apb(1'b1, 12'h010, 32'hffffffff);
    apb(1'b0, 12'h010, '0); chk(rdv, 32'h0);
    apb(1'b1, 12'h004, 32'h00007fff);
    apb(1'b0, 12'h004, '0); chk(rdv, 32'h00007fff);
    // edge select resets to falling
    stim(17); apb(1'b0, 12'h000, '0); chk(rdv, 32'h2);
    apb(1'b1, 12'h000, 32'h00007ffd);
    apb(1'b0, 12'h000, '0); chk(rdv, 32'h0);
    apb(1'b1, 12'h000, 32'h00007fff);
    apb(1'b0, 12'h000, '0); chk(rdv, 32'h0);
    apb(1'b1, 12'h00c, 32'h000000ff);
    for (int i = 0; i < 15; i++) begin
      stim(src_a[i]);
      take_chk(1'b1, vec_a[i]);
      apb(1'b0, 12'h000, '0); chk(rdv, 32'h0);
    end
    ev[8] <= 1'b1;
    @(posedge clk);
    ev[8] <= 1'b0;
    @(posedge clk);
    chk(stop_rel, 1'b1);
    take_chk(1'b1, 16'hffee);
    ev <= 11'h060;
    @(posedge clk);
    ev <= '0;
    repeat (2) @(posedge clk);
    take_chk(1'b1, 16'hfff2);
    apb(1'b0, 12'h000, '0); chk(rdv, 32'h20);
    take_chk(1'b1, 16'hfff0);
    mask <= 1'b1;
    stim(9);
    chk(pend, 1'b0);
    take_chk(1'b0, 16'h0);
    apb(1'b0, 12'h000, '0); chk(rdv, 32'h80);
    mask <= 1'b0;
    take_chk(1'b1, 16'hffec);
    apb(1'b1, 12'h004, 32'h00007fdf);
    stim(6); take_chk(1'b0, 16'h0);
    apb(1'b0, 12'h000, '0); chk(rdv, 32'h20);
    apb(1'b1, 12'h000, 32'h00007fdf);
    apb(1'b0, 12'h000, '0); chk(rdv, 32'h0);
    apb(1'b1, 12'h004, 32'h00007fff);
    sel[0] <= 1'b0;
    stim(0); stim(1); apb(1'b0, 12'h000, '0); chk(rdv, 32'h0);
    sel[0] <= 1'b1;
    software_break_instruction  <= 1'b1;
    mask <= 1'b1;
    take_chk(1'b1, 16'hffdc);
    mask <= 1'b0;
    stim(9); take_chk(1'b1, 16'hffec);
    software_break_instruction <= 1'b0;
    take_chk(1'b0, 16'h0);
    apb(1'b1, 12'h008, 32'h0000001f);
    apb(1'b0, 12'h008, '0); chk(rdv, 32'h1f);
    stim(7);
    chk(pend, 1'b1);
    apb(1'b0, 12'h014, '0);
    chk(rdv, 32'h10);
    take_chk(1'b1, 16'hfffa);
    take_chk(1'b1, 16'hffe6);
    for (int j = 0; j < 3; j++) begin
      stim(src_b[j]); take_chk(1'b1, vec_b[j]);
    end
    apb(1'b1, 12'h008, 32'h0);
    stim(7); take_chk(1'b0, 16'h0);
    // mid-run reset: reset fetch again, registers back to reset values
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk(vvalid, 1'b1);
    chk(vaddr, 16'hfffc);
    apb(1'b0, 12'h004, '0);
    chk(rdv, 32'h0);
    finish_test;
  end

  // a hang is cut short well past the few hundred cycles of the tests
  initial begin
    #100000;
    num_errors++;
    finish_test;
  end
endmodule // vectored_fixed_priority_irq_tb_top
